/* verilog/scpc_pkg.sv */
// package: constants, types and helpers of the system clock and power control
package scpc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_STBY_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLK_MODE = 4'h1;
  localparam logic [3:0] ADDR_MOD_HALT = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // standby_control fields
  localparam int STBY_SEL_BIT = 7;
  localparam int WAKE_SEL_HI = 6;
  localparam int WAKE_SEL_LO = 4;
  localparam logic [7:0] STBY_CTRL_RST = 8'h00;
  localparam logic [7:0] STBY_CTRL_MASK = 8'hF0;

  // clock_mode_control fields
  localparam int SUBSLEEP_SEL_BIT = 7;
  localparam int ACT_DIV_HI = 4;
  localparam int ACT_DIV_LO = 2;
  localparam logic [7:0] CLK_MODE_RST = 8'h00;
  localparam logic [7:0] CLK_MODE_MASK = 8'h9C;

  // module_halt_control fields
  localparam int MOD_HALT_LO = 1;
  localparam logic [7:0] MOD_HALT_RST = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PRESC_W = 13;
  localparam int TAP_SEL_W = 4;
  localparam int WAIT_W = 18;
  localparam logic [WAIT_W-1:0] WAIT_STATES_5 = 18'h00400;
  localparam logic [WAIT_W-1:0] WAIT_STATES_6 = 18'h00080;
  localparam logic [WAIT_W-1:0] WAIT_STATES_7 = 18'h00010;
  localparam int ACT_DIV_CNT_W = 6;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    SCPC_ACTIVE = 3'b000,
    SCPC_STANDBY = 3'b001,
    SCPC_WAKE = 3'b011,
    SCPC_SLEEP = 3'b100,
    SCPC_SUBSLEEP = 3'b101
  } scpc_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } scpc_bus_req_s;

  // true on the state in which a 2**sel tap of the prescaler completes
  function automatic logic scpc_tap_hit(input logic [PRESC_W-1:0] cnt,
                                        input logic [TAP_SEL_W-1:0] sel);
    logic [PRESC_W:0] mask;
    mask = (14'h0001 << sel) - 14'h0001;
    return (sel != 4'h0) && (sel <= 4'hD) &&
           ((cnt & mask[PRESC_W-1:0]) == mask[PRESC_W-1:0]);
  endfunction : scpc_tap_hit

endpackage : scpc_pkg

/* verilog/scpc_clk_div.sv */
// module: active-mode system clock enable from the oscillator clock
`timescale 1ns/1ns
`default_nettype none
module scpc_clk_div
  import scpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [2:0] div_code_in,
  output logic sys_en_out
);

  logic [ACT_DIV_CNT_W-1:0] cnt;
  logic [ACT_DIV_CNT_W-1:0] mask;

  // 0XX passes every oscillator edge, 1XX divides by 8 to 64
  always_comb
  begin
    unique case (div_code_in)
      3'h4: mask = 6'h07;
      3'h5: mask = 6'h0F;
      3'h6: mask = 6'h1F;
      3'h7: mask = 6'h3F;
      default: mask = 6'h00;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      cnt <= 6'h00;
    else
      cnt <= cnt + 6'h01;
  end

  assign sys_en_out = ((cnt & mask) == mask); // RQ7

endmodule : scpc_clk_div
`default_nettype wire

/* verilog/scpc_prescaler.sv */
// module: 13-bit free-running peripheral prescaler
`timescale 1ns/1ns
`default_nettype none
module scpc_prescaler
  import scpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic clr_in,
  input wire logic adv_in,
  output logic [PRESC_W-1:0] count_out
);

  always_ff @(posedge mclk_in)
  begin
    if (srst_in || clr_in)
      count_out <= 13'h0000; // RQ2 RQ3
    else if (adv_in)
      count_out <= count_out + 13'h0001; // RQ1
  end

endmodule : scpc_prescaler
`default_nettype wire

/* verilog/scpc_top.sv */
// module: system clock and power-down mode control, top level
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// [RQ1] peripheral prescaler is 13 bits, advancing once per system clock state
// [RQ2] reset clears the prescaler; it counts right after reset release
// [RQ3] standby and subsleep stop and clear the prescaler
// [RQ4] software can neither read nor write the prescaler
// [RQ5] taps /2 to /8192 shared; each peripheral picks its own ratio
// [RQ6] in active and sleep the prescaler runs on the divided system clock
// [RQ7] system clock is oscillator, or oscillator /8, /16, /32 or /64
// [RQ8] sleep stops the processor clock; peripherals keep running
// [RQ9] standby stops processor and all peripherals
// [RQ10] subsleep stops everything and holds the I/O port outputs
// [RQ11] each peripheral can be halted on its own by a module halt bit
// [RQ12] sleep instruction enters sleep if standby select is 0, else standby, or subsleep if subsleep select is 1
// [RQ13] wake from standby waits 8192..131072, 1024, 128 or 16 states by code
// [RQ14] software picks a wake wait code lasting at least 6.5 ms
// [RQ15] standby control bits 3 to 0 read as zero
// [RQ16] division code 0XX or 100..111; applies at next sleep instruction
// [RQ17] a counter started by the waking interrupt times the wake wait
module scpc_top
  import scpc_pkg::*;
#(
  parameter int NUM_PERIPH = 5,
  parameter int WAIT_STATES_0 = 8192,
  parameter int WAIT_STATES_1 = 16384,
  parameter int WAIT_STATES_2 = 32768,
  parameter int WAIT_STATES_3 = 65536,
  parameter int WAIT_STATES_4 = 131072
)
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire scpc_bus_req_s bus_req_in,
  output logic [DATA_W-1:0] bus_rdata_out,
  input wire logic sleep_exec_in,
  input wire logic wake_irq_in,
  input wire logic [NUM_PERIPH*TAP_SEL_W-1:0] periph_div_sel_in,
  output logic cpu_clk_en_out,
  output logic sys_clk_en_out,
  output logic [NUM_PERIPH-1:0] periph_clk_en_out,
  output logic io_hold_out,
  output scpc_mode_e mode_out
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (NUM_PERIPH < 1 || NUM_PERIPH > 7)
  begin : g_bad_periph
    $error("scpc_top: NUM_PERIPH must be 1 to 7");
  end
  if (WAIT_STATES_0 < 2 || WAIT_STATES_0 >= (1 << WAIT_W) ||
      WAIT_STATES_1 < 2 || WAIT_STATES_1 >= (1 << WAIT_W) ||
      WAIT_STATES_2 < 2 || WAIT_STATES_2 >= (1 << WAIT_W) ||
      WAIT_STATES_3 < 2 || WAIT_STATES_3 >= (1 << WAIT_W) ||
      WAIT_STATES_4 < 2 || WAIT_STATES_4 >= (1 << WAIT_W))
  begin : g_bad_wait
    $error("scpc_top: wait counts must be 2 to 2**18-1");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] stby_ctrl;
  logic [7:0] clk_mode;
  logic [NUM_PERIPH-1:0] mod_halt;
  logic [2:0] act_div_applied;
  scpc_mode_e mode;
  scpc_mode_e next_mode;
  logic [WAIT_W-1:0] wait_cnt;
  logic sys_en;
  logic [PRESC_W-1:0] presc;
  logic presc_run;
  logic presc_clr;

  wire logic stby_sel = stby_ctrl[STBY_SEL_BIT];
  wire logic subsleep_sel = clk_mode[SUBSLEEP_SEL_BIT];
  wire logic [2:0] wake_code = stby_ctrl[WAKE_SEL_HI:WAKE_SEL_LO];
  wire logic [2:0] div_field = clk_mode[ACT_DIV_HI:ACT_DIV_LO];

  function automatic logic [WAIT_W-1:0] wait_states(input logic [2:0] c);
    unique case (c)
      3'h0: return WAIT_W'(WAIT_STATES_0);
      3'h1: return WAIT_W'(WAIT_STATES_1);
      3'h2: return WAIT_W'(WAIT_STATES_2);
      3'h3: return WAIT_W'(WAIT_STATES_3);
      3'h4: return WAIT_W'(WAIT_STATES_4);
      3'h5: return WAIT_STATES_5;
      3'h6: return WAIT_STATES_6;
      default: return WAIT_STATES_7;
    endcase
  endfunction : wait_states

  // ****************************************************************
  // register writes
  // ****************************************************************
  // the prescaler has no address, so no access can touch it
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      stby_ctrl <= STBY_CTRL_RST;
    else if (bus_req_in.wr && bus_req_in.addr == ADDR_STBY_CTRL)
      stby_ctrl <= bus_req_in.wdata & STBY_CTRL_MASK; // RQ15 RQ4
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      clk_mode <= CLK_MODE_RST;
    else if (bus_req_in.wr && bus_req_in.addr == ADDR_CLK_MODE)
      clk_mode <= bus_req_in.wdata & CLK_MODE_MASK;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      mod_halt <= MOD_HALT_RST[MOD_HALT_LO +: NUM_PERIPH];
    else if (bus_req_in.wr && bus_req_in.addr == ADDR_MOD_HALT)
      mod_halt <= bus_req_in.wdata[MOD_HALT_LO +: NUM_PERIPH];
  end

  // written code waits for the sleep instruction so the clock never
  // changes rate under running software
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      act_div_applied <= 3'h0;
    else if (sleep_exec_in && mode == SCPC_ACTIVE)
      act_div_applied <= div_field; // RQ16
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !bus_req_in.rd)
      bus_rdata_out <= 8'h00;
    else
    begin
      unique case (bus_req_in.addr)
        ADDR_STBY_CTRL: bus_rdata_out <= stby_ctrl & STBY_CTRL_MASK; // RQ15
        ADDR_CLK_MODE: bus_rdata_out <= clk_mode & CLK_MODE_MASK;
        ADDR_MOD_HALT:
          bus_rdata_out <= 8'(mod_halt) << MOD_HALT_LO;
        ADDR_STATUS: bus_rdata_out <= {5'h00, mode};
        default: bus_rdata_out <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // system clock divider and prescaler
  // ****************************************************************
  scpc_clk_div u_clk_div (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .div_code_in(act_div_applied),
    .sys_en_out(sys_en)
  );

  assign presc_run = (mode == SCPC_ACTIVE || mode == SCPC_SLEEP);
  assign presc_clr = !presc_run; // RQ3

  scpc_prescaler u_prescaler (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .clr_in(presc_clr),
    .adv_in(sys_en && presc_run), // RQ6 RQ1
    .count_out(presc)
  );

  // ****************************************************************
  // power mode sequencing
  // ****************************************************************
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      SCPC_ACTIVE:
        if (sleep_exec_in)
          next_mode = !stby_sel ? SCPC_SLEEP : // RQ12
                      (subsleep_sel ? SCPC_SUBSLEEP : SCPC_STANDBY);
      SCPC_SLEEP:
        if (wake_irq_in)
          next_mode = SCPC_ACTIVE;
      SCPC_STANDBY, SCPC_SUBSLEEP:
        if (wake_irq_in)
          next_mode = SCPC_WAKE; // RQ17
      SCPC_WAKE:
        if (sys_en && wait_cnt == 18'h00001)
          next_mode = SCPC_ACTIVE; // RQ13
      default: next_mode = SCPC_ACTIVE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      mode <= SCPC_ACTIVE;
    else
      mode <= next_mode;
  end

  // the wait counts system clock states, so it scales with the divider
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      wait_cnt <= 18'h00000;
    else if (mode != SCPC_WAKE && next_mode == SCPC_WAKE)
      wait_cnt <= wait_states(wake_code); // RQ13 RQ17
    else if (mode == SCPC_WAKE && sys_en && wait_cnt != 18'h00000)
      wait_cnt <= wait_cnt - 18'h00001; // RQ17
  end

  // ****************************************************************
  // clock enables and port hold
  // ****************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      cpu_clk_en_out <= 1'b0;
    else
      cpu_clk_en_out <= sys_en && mode == SCPC_ACTIVE; // RQ8 RQ9
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      sys_clk_en_out <= 1'b0;
    else
      sys_clk_en_out <= sys_en && presc_run; // RQ8 RQ9 RQ10
  end

  // each peripheral is registered one oscillator clock after its tap completes
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      periph_clk_en_out <= '0;
    else
      for (int i = 0; i < NUM_PERIPH; i++)
        periph_clk_en_out[i] <= sys_en && presc_run && !mod_halt[i] && // RQ11
          scpc_tap_hit(presc,
                       periph_div_sel_in[i*TAP_SEL_W +: TAP_SEL_W]); // RQ5
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      io_hold_out <= 1'b0;
    else
      io_hold_out <= (mode == SCPC_SUBSLEEP); // RQ10
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      mode_out <= SCPC_ACTIVE;
    else
      mode_out <= mode;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  AST_PRESC_ADVANCE: assert property ( // RQ1
    (sys_en && presc_run) |=> presc == $past(presc) + 13'h0001)
    else $error("prescaler did not advance on a system clock state");

  AST_PRESC_HOLD: assert property ( // RQ1
    (!sys_en && presc_run) |=> presc == $past(presc))
    else $error("prescaler moved without a system clock state");

  AST_RESET_CLEAR: assert property ( // RQ2
    @(posedge mclk_in) disable iff (1'b0)
    srst_in |=> presc == 13'h0000 && mode == SCPC_ACTIVE)
    else $error("reset left prescaler or mode uncleared");

  AST_STOP_CLEAR: assert property ( // RQ3
    (mode == SCPC_STANDBY || mode == SCPC_SUBSLEEP) |=> presc == 13'h0000)
    else $error("prescaler not cleared in standby or subsleep");

  AST_SLEEP_CPU_OFF: assert property ( // RQ8
    (mode == SCPC_SLEEP && sys_en) |=> !cpu_clk_en_out && sys_clk_en_out)
    else $error("sleep clock gating wrong");

  AST_STANDBY_ALL_OFF: assert property ( // RQ9
    (mode == SCPC_STANDBY || mode == SCPC_WAKE)
    |=> !cpu_clk_en_out && !sys_clk_en_out && periph_clk_en_out == '0)
    else $error("clock ran while halted");

  AST_SUBSLEEP_HOLD: assert property ( // RQ10
    mode == SCPC_SUBSLEEP |=> io_hold_out && !sys_clk_en_out)
    else $error("subsleep did not hold ports");

  AST_MOD_HALT: assert property ( // RQ11
    mod_halt[0] |=> !periph_clk_en_out[0])
    else $error("halted peripheral got a clock");

  AST_SLEEP_SELECT: assert property ( // RQ12
    (mode == SCPC_ACTIVE && sleep_exec_in)
    |=> mode == ($past(stby_sel) ? ($past(subsleep_sel) ?
        SCPC_SUBSLEEP : SCPC_STANDBY) : SCPC_SLEEP))
    else $error("wrong mode after sleep instruction");

  AST_WAKE_LOAD: assert property ( // RQ13
    (mode != SCPC_WAKE && next_mode == SCPC_WAKE)
    |=> wait_cnt == wait_states($past(wake_code)))
    else $error("wake wait loaded with wrong count");

  AST_WAKE_RELEASE: assert property ( // RQ17
    (mode == SCPC_WAKE && wait_cnt > 18'h00001) |=> mode == SCPC_WAKE)
    else $error("wake wait ended early");

  AST_RSVD_READ: assert property ( // RQ15
    (bus_req_in.rd && bus_req_in.addr == ADDR_STBY_CTRL)
    |=> bus_rdata_out[3:0] == 4'h0 &&
        bus_rdata_out[7:4] == $past(stby_ctrl[7:4]))
    else $error("standby control read wrong");

  AST_DIV_APPLY: assert property ( // RQ16
    !(sleep_exec_in && mode == SCPC_ACTIVE)
    |=> act_div_applied == $past(act_div_applied))
    else $error("division changed without sleep instruction");

  COV_SLEEP_WAKE: cover property (
    mode == SCPC_SLEEP ##1 wake_irq_in ##1 mode == SCPC_ACTIVE);
  COV_STANDBY_WAKE: cover property (
    mode == SCPC_WAKE ##1 mode == SCPC_ACTIVE);
  COV_SUBSLEEP: cover property (mode == SCPC_SUBSLEEP);
  COV_DIV64: cover property (act_div_applied == 3'h7 && sys_en);

endmodule : scpc_top
`default_nettype wire

/* test/test_scpc_top.sv */
// testbench: self-checking bench of the system clock and power control
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("FAIL %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module test_scpc_top
  import scpc_pkg::*;
;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  scpc_bus_req_s bus_req_in = '0;
  logic [7:0] bus_rdata_out;
  logic sleep_exec_in = 1'b0;
  logic wake_irq_in = 1'b0;
  logic [19:0] periph_div_sel_in = {4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
  logic cpu_clk_en_out;
  logic sys_clk_en_out;
  logic [4:0] periph_clk_en_out;
  logic io_hold_out;
  scpc_mode_e mode_out;
  int mismatches = 0;
  int compares = 0;
  int n_cpu, n_sys, t, prev_div, d, s, e;
  int n_per[5];
  // model: expected wake waits and division factors
  int waits[8] = '{20, 24, 28, 32, 36, 1024, 128, 16};
  int divs[5] = '{8, 16, 32, 64, 1};
  logic [2:0] codes[5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [7:0] rd_v;
  logic [4:0] halt;
  scpc_mode_e exp_mode;

  scpc_top #(
    .WAIT_STATES_0(20),
    .WAIT_STATES_1(24),
    .WAIT_STATES_2(28),
    .WAIT_STATES_3(32),
    .WAIT_STATES_4(36)
  ) scpc_top_i (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .bus_req_in(bus_req_in),
    .bus_rdata_out(bus_rdata_out),
    .sleep_exec_in(sleep_exec_in),
    .wake_irq_in(wake_irq_in),
    .periph_div_sel_in(periph_div_sel_in),
    .cpu_clk_en_out(cpu_clk_en_out),
    .sys_clk_en_out(sys_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out),
    .io_hold_out(io_hold_out),
    .mode_out(mode_out)
  );

  always #5 mclk_in = ~mclk_in;

  // ****************************************************************
  // bus and power tasks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] dv);
    @(posedge mclk_in);
    bus_req_in <= '{addr: a, wdata: dv, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_req_in.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] ex);
    @(posedge mclk_in);
    bus_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_req_in.rd <= 1'b0;
    #1;
    rd_v = bus_rdata_out;
    `CHK("register", ex, rd_v)
  endtask : chk_reg

  task automatic pulse(input logic slp);
    @(posedge mclk_in);
    if (slp)
      sleep_exec_in <= 1'b1;
    else
      wake_irq_in <= 1'b1;
    @(posedge mclk_in);
    sleep_exec_in <= 1'b0;
    wake_irq_in <= 1'b0;
  endtask : pulse

  task automatic cnt(input int n);
    n_cpu = 0;
    n_sys = 0;
    foreach (n_per[k])
      n_per[k] = 0;
    repeat (n)
    begin
      @(posedge mclk_in);
      #1;
      // an unknown enable would count as zero and pass a stop check
      `CHK("known", 1'b0, $isunknown({cpu_clk_en_out, sys_clk_en_out, periph_clk_en_out}))
      n_cpu += int'(cpu_clk_en_out);
      n_sys += int'(sys_clk_en_out);
      foreach (n_per[k])
        n_per[k] += int'(periph_clk_en_out[k]);
    end
  endtask : cnt

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    #500000;
    mismatches++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h772d));
    repeat (6) @(posedge mclk_in);
    srst_in <= 1'b0;
    // reset values, unmapped place
    for (int a = 0; a < 4; a++)
      chk_reg(a[3:0], 8'h00);
    wr(4'h9, 8'($urandom()));
    chk_reg(4'h9, 8'h00);
    $display("test reset done");
    // reserved bits drop, writable bits keep
    d = $urandom();
    wr(ADDR_STBY_CTRL, d[7:0]);
    chk_reg(ADDR_STBY_CTRL, d[7:0] & 8'hF0);
    wr(ADDR_CLK_MODE, d[7:0]);
    chk_reg(ADDR_CLK_MODE, d[7:0] & 8'h9C);
    wr(ADDR_MOD_HALT, d[7:0]);
    chk_reg(ADDR_MOD_HALT, d[7:0] & 8'h3E);
    for (int a = 0; a < 3; a++)
      wr(a[3:0], 8'h00);
    $display("test registers done");
    // prescaler taps, per-module halt; stray writes must not disturb it
    halt = 5'($urandom());
    // last peripheral gets a random tap, including the no-clock codes
    d = $urandom_range(9);
    d = (d > 7) ? d + 6 : d;
    periph_div_sel_in[19:16] <= 4'(d);
    wr(ADDR_MOD_HALT, {2'b00, halt, 1'b0});
    wr(4'hF, 8'($urandom()));
    cnt(128);
    `CHK("cpu", 128, n_cpu)
    `CHK("sys", 128, n_sys)
    for (int k = 0; k < 5; k++)
    begin
      s = (k == 4) ? d : k + 1;
      e = (halt[k] || s == 0 || s > 13) ? 0 : (128 >> s);
      `CHK("periph", e, n_per[k])
    end
    wr(ADDR_MOD_HALT, 8'h00);
    $display("test taps done");
    // division codes apply only at a sleep instruction
    prev_div = 1;
    for (int j = 0; j < 5; j++)
    begin
      wr(ADDR_CLK_MODE, {3'b000, codes[j], 2'b00});
      cnt(128);
      `CHK("old rate", 128 / prev_div, n_sys)
      pulse(1'b1);
      repeat (2) @(posedge mclk_in);
      #1;
      `CHK("mode", SCPC_SLEEP, mode_out)
      cnt(128);
      `CHK("cpu sleep", 0, n_cpu)
      `CHK("sys sleep", 128 / divs[j], n_sys)
      `CHK("per sleep", 64 / divs[j], n_per[0])
      pulse(1'b0);
      repeat (2) @(posedge mclk_in);
      #1;
      `CHK("mode", SCPC_ACTIVE, mode_out)
      cnt(128);
      `CHK("cpu rate", 128 / divs[j], n_cpu)
      prev_div = divs[j];
    end
    $display("test divider done");
    // standby with wake wait codes 0 to 6, subsleep with code 7
    for (int j = 0; j < 8; j++)
    begin
      wr(ADDR_STBY_CTRL, {1'b1, 3'(j), 4'hA});
      if (j == 7)
        wr(ADDR_CLK_MODE, 8'h80);
      exp_mode = (j == 7) ? SCPC_SUBSLEEP : SCPC_STANDBY;
      pulse(1'b1);
      repeat (2) @(posedge mclk_in);
      #1;
      `CHK("mode", exp_mode, mode_out)
      cnt(16);
      `CHK("cpu stop", 0, n_cpu)
      `CHK("sys stop", 0, n_sys)
      `CHK("per stop", 0, n_per[0] + n_per[4])
      `CHK("io hold", j == 7, io_hold_out)
      pulse(1'b0);
      t = 0;
      do
      begin
        @(posedge mclk_in);
        #1;
        t++;
      end while (mode_out !== SCPC_WAKE && t < 8);
      t = 0;
      while (mode_out === SCPC_WAKE && t < 1100)
      begin
        @(posedge mclk_in);
        #1;
        t++;
      end
      `CHK("wake wait", waits[j], t)
      `CHK("mode", SCPC_ACTIVE, mode_out)
      if (j == 7)
        wr(ADDR_CLK_MODE, 8'h00);
    end
    chk_reg(ADDR_STATUS, 8'h00);
    $display("test standby done");
    complete_run();
  end
endmodule : test_scpc_top
`default_nettype wire
